// File: rtl/adc_out_path.sv
// Serial-programmed output path: gain, test patterns and output FIFO
`timescale 1ns/1ps
`include "adc_out_map.svh"

module sample_fifo #(
	parameter int W = 56,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fifo_s;
	fifo_s q;
	fifo_s d;
	logic full;
	assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = q.wp != q.rp;
	assign out_data = q.mem[q.rp[AW-1:0]];
	always_comb begin
		d = q;
		if (in_valid && !full) begin
			d.mem[q.wp[AW-1:0]] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			d.rp = q.rp + 1'b1;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module adc_out_path
	import adc_out_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Serial control port
	input wire logic SEN_N,
	input wire logic SCLK,
	input wire logic SDATA,
	output logic SERIAL_DATA_OUT_PIN,
	output logic SERIAL_DATA_OUT_PIN_OE,
	// Converter samples
	input wire logic IN_VALID,
	output logic IN_READY,
	input wire samples_s IN_DATA,
	// Output stream
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output samples_s OUT_DATA,
	// Output driver
	output logic [5:0] LVDS_SWING
);
	typedef struct packed {
		regs_s r;
		logic sclk;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [7:0] sdo;
		logic [3:0] tog;
		logic [3:0][2:0] div;
		logic [3:0][13:0] ramp;
	} state_s;
	state_s q;
	state_s d;
	logic rise;
	logic wr;
	logic acc;
	logic [7:0] wr_a;
	logic [7:0] wr_v;
	logic [3:0] tog_nx;
	logic [3:0][2:0] div_nx;
	logic [3:0][13:0] ramp_nx;
	samples_s proc;

	////////////////////////////////////////////////////////////////////////////
	// Register access

	function automatic logic [7:0] rd_reg(regs_s r, logic [7:0] a);
		case (a)
			`A_CTRL: rd_reg = {7'h00, r.readout};
			`A_SWING: rd_reg = {r.swing, 2'h0};
			`A_CHA: rd_reg = r.ch[0];
			`A_CHB: rd_reg = r.ch[1];
			`A_CHC: rd_reg = r.ch[2];
			`A_CHD: rd_reg = r.ch[3];
			`A_PAT_HI: rd_reg = {2'h0, r.custom[13:8]};
			`A_PAT_LO: rd_reg = r.custom[7:0];
			`A_DIGEN: rd_reg = {4'h0, r.digen, 3'h0};
			`A_BURST: rd_reg = {r.burst[1], r.burst[0], 6'h00};
			`A_UNLOCK: rd_reg = {6'h00, r.unlock};
			default: rd_reg = 8'h00;
		endcase
	endfunction

	function automatic regs_s wr_reg(regs_s r, logic [7:0] a, logic [7:0] v);
		regs_s n;
		n = r;
		case (a)
			`A_CTRL: begin
				if (v[`B_RESET]) begin
					n = '0;
				end else begin
					n.readout = v[`B_READOUT];
				end
			end
			`A_SWING: n.swing = v[7:2];
			`A_CHA: n.ch[0] = chan_cfg_s'(v);
			`A_CHB: n.ch[1] = chan_cfg_s'(v);
			`A_CHC: n.ch[2] = chan_cfg_s'(v);
			`A_CHD: n.ch[3] = chan_cfg_s'(v);
			`A_PAT_HI: n.custom[13:8] = v[5:0];
			`A_PAT_LO: n.custom[7:0] = v;
			`A_DIGEN: n.digen = v[`B_DIGEN];
			`A_BURST: n.burst = {v[`B_BURST_CD], v[`B_BURST_AB]};
			`A_UNLOCK: n.unlock = v[1:0];
			default: n = r;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Channel data path

	function automatic logic [10:0] gain_factor(logic [3:0] g);
		case (g)
			4'h0: gain_factor = 11'h200;
			4'h1: gain_factor = 11'h21e;
			4'h2: gain_factor = 11'h23e;
			4'h3: gain_factor = 11'h261;
			4'h4: gain_factor = 11'h285;
			4'h5: gain_factor = 11'h2ab;
			4'h6: gain_factor = 11'h2d3;
			4'h7: gain_factor = 11'h2fe;
			4'h8: gain_factor = 11'h32b;
			4'h9: gain_factor = 11'h35c;
			4'ha: gain_factor = 11'h38e;
			4'hb: gain_factor = 11'h3c4;
			4'hc: gain_factor = 11'h3fe;
			default: gain_factor = 11'h200;
		endcase
	endfunction

	function automatic sample_t chan_out(sample_t raw, chan_cfg_s c, logic m14, logic digen, logic t,
			sample_t ramp, sample_t cust);
		logic [24:0] prod;
		sample_t g;
		sample_t conv;
		prod = 25'(raw) * 25'(gain_factor(c.gain));
		prod = prod >> `GAIN_FRAC;
		if (!digen || c.skip) begin
			g = raw;
		end else if (prod[24:14] != '0) begin
			g = `ONES14;
		end else begin
			g = prod[13:0];
		end
		conv = m14 ? g : {3'h0, g[13:3]};
		case (c.pat)
			PAT_NORMAL: chan_out = conv;
			PAT_ZEROS: chan_out = '0;
			PAT_ONES: chan_out = m14 ? `ONES14 : `ONES11;
			PAT_TOGGLE: begin
				if (m14) begin
					chan_out = t ? `TOG14_B : `TOG14_A;
				end else begin
					chan_out = t ? `TOG11_B : `TOG11_A;
				end
			end
			PAT_RAMP: chan_out = m14 ? ramp : {3'h0, ramp[10:0]};
			PAT_CUSTOM: chan_out = m14 ? cust : {3'h0, cust[13:3]};
			default: chan_out = conv;
		endcase
	endfunction

	assign acc = IN_VALID && IN_READY;

	for (genvar i = 0; i < 4; i++) begin : g_ch
		logic m14;
		logic on_ramp;
		assign m14 = q.r.burst[i/2];
		assign on_ramp = q.r.ch[i].pat == PAT_RAMP;
		assign div_nx[i] = on_ramp ? q.div[i] + 3'h1 : 3'h0;
		assign tog_nx[i] = (q.r.ch[i].pat == PAT_TOGGLE) ? q.tog[i] ^ acc : 1'b0;
		always_comb begin
			if (!on_ramp) begin
				ramp_nx[i] = '0;
			end else if (m14) begin
				ramp_nx[i] = q.ramp[i] + 14'h1;
			end else if (q.div[i] == `RAMP_DIV) begin
				ramp_nx[i] = {3'h0, q.ramp[i][10:0] + 11'h1};
			end else begin
				ramp_nx[i] = q.ramp[i];
			end
		end
		assign proc.s[i] = chan_out(IN_DATA.s[i], q.r.ch[i], m14, q.r.digen, q.tog[i],
			q.ramp[i], q.r.custom);
	end

	sample_fifo #(
		.W($bits(samples_s)),
		.DEPTH(8)
	) u_fifo (
		.clock(CLOCK),
		.rst(RST),
		.in_valid(IN_VALID),
		.in_ready(IN_READY),
		.in_data(proc),
		.out_valid(OUT_VALID),
		.out_ready(OUT_READY),
		.out_data(OUT_DATA)
	);

	////////////////////////////////////////////////////////////////////////////
	// Serial port and state

	assign rise = SCLK && !q.sclk;
	assign wr_a = d.sh[15:8];
	assign wr_v = d.sh[7:0];

	always_comb begin
		d = q;
		wr = 1'b0;
		d.sclk = SCLK;
		d.tog = tog_nx;
		d.div = div_nx;
		d.ramp = ramp_nx;
		if (SEN_N) begin
			d.cnt = '0;
		end else if (rise && q.cnt < `FRAME_BITS) begin
			d.sh = {q.sh[14:0], SDATA};
			d.cnt = q.cnt + 5'h1;
			if (q.cnt >= `ADDR_BITS) begin
				d.sdo = {q.sdo[6:0], 1'b0};
			end
			if (d.cnt == `ADDR_BITS) begin
				d.sdo = rd_reg(q.r, d.sh[7:0]);
			end
			if (d.cnt == `FRAME_BITS) begin
				wr = 1'b1;
				d.r = wr_reg(q.r, d.sh[15:8], d.sh[7:0]);
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign SERIAL_DATA_OUT_PIN = q.sdo[7];
	assign SERIAL_DATA_OUT_PIN_OE = q.r.readout;
	assign LVDS_SWING = (q.r.unlock == `UNLOCK_KEY) ? q.r.swing : 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	a_sw_reset: assert property (wr && wr_a == `A_CTRL && wr_v[`B_RESET] |=> q.r == '0)
		else $error("soft reset left a register set");
	a_readout_on: assert property (wr && wr_a == `A_CTRL && wr_v == 8'h01 |=> SERIAL_DATA_OUT_PIN_OE)
		else $error("readback not enabled");
	a_readout_off: assert property (wr && wr_a == `A_CTRL && !wr_v[`B_READOUT] |=> !SERIAL_DATA_OUT_PIN_OE [*2])
		else $error("serial output driven while readback off");
	a_swing_lock: assert property (wr && wr_a == `A_UNLOCK && wr_v[1:0] != `UNLOCK_KEY
		|=> LVDS_SWING == 6'h00)
		else $error("swing applied while locked");
	a_swing_code: assert property (wr && wr_a == `A_SWING && q.r.unlock == `UNLOCK_KEY
		|=> LVDS_SWING == $past(wr_v) >> 2)
		else $error("swing code not applied");
	a_chan_isolate: assert property (acc && q.r.ch[0].pat == PAT_ZEROS && q.r.ch[1] == 8'h00
		&& q.r.burst[0] |-> proc.s[0] == '0 && proc.s[1] == IN_DATA.s[1])
		else $error("pattern leaked to another channel");
	a_gain_max: assert property (acc && q.r.ch[0] == 8'hc0 && q.r.burst[0] && q.r.digen
		&& IN_DATA.s[0] < 14'h2000 |-> 15'(proc.s[0]) <= {IN_DATA.s[0], 1'b0}
		&& 15'(proc.s[0]) + 15'(IN_DATA.s[0][13:8]) + 15'h0001 >= {IN_DATA.s[0], 1'b0})
		else $error("6 dB gain wrong");
	a_tog_11: assert property ((acc && q.r.ch[0].pat == PAT_TOGGLE && !q.r.burst[0] && !wr) ##1
		(acc && q.r.ch[0].pat == PAT_TOGGLE) |-> proc.s[0] == ($past(proc.s[0]) ^ `ONES11))
		else $error("11-bit toggle did not alternate");
	a_tog_14: assert property ((acc && q.r.ch[0].pat == PAT_TOGGLE && q.r.burst[0] && !wr) ##1
		(acc && q.r.ch[0].pat == PAT_TOGGLE) |-> proc.s[0] == ($past(proc.s[0]) ^ `ONES14))
		else $error("14-bit toggle did not alternate");
	a_ramp_hold: assert property (q.r.ch[0].pat == PAT_RAMP && !q.r.burst[0] && !wr
		&& q.div[0] != `RAMP_DIV |=> q.ramp[0] == $past(q.ramp[0]))
		else $error("11-bit ramp stepped early");
	a_ramp_step: assert property (q.r.ch[0].pat == PAT_RAMP && q.r.burst[0] && !wr
		|=> q.ramp[0] == $past(q.ramp[0]) + 14'h1)
		else $error("14-bit ramp did not step");
	a_custom_11: assert property (acc && q.r.ch[0].pat == PAT_CUSTOM && !q.r.burst[0]
		|-> proc.s[0] == {3'h0, q.r.custom[13:3]})
		else $error("11-bit custom word wrong");
	a_custom_14: assert property (acc && q.r.ch[0].pat == PAT_CUSTOM && q.r.burst[0]
		|-> proc.s[0] == q.r.custom)
		else $error("14-bit custom word wrong");

	c_sw_reset: cover property (wr && wr_a == `A_CTRL && wr_v[`B_RESET]);
	c_fifo_full: cover property (IN_VALID && !IN_READY);
	c_ramp_wrap: cover property (q.r.ch[0].pat == PAT_RAMP && q.ramp[0] == `ONES11 && q.div[0] == `RAMP_DIV);
	c_readback: cover property (SERIAL_DATA_OUT_PIN_OE && d.cnt == `FRAME_BITS && rise);
endmodule

// File: common/adc_out_map.svh
// Register addresses, bit positions and fixed codes of the output path
`ifndef ADC_OUT_MAP_SVH
`define ADC_OUT_MAP_SVH
`define A_CTRL 8'h00
`define A_SWING 8'h01
`define A_CHB 8'h25
`define A_CHA 8'h2b
`define A_CHD 8'h31
`define A_CHC 8'h37
`define A_PAT_HI 8'h3f
`define A_PAT_LO 8'h40
`define A_DIGEN 8'h42
`define A_BURST 8'h44
`define A_UNLOCK 8'hf1
`define B_RESET 1
`define B_READOUT 0
`define B_DIGEN 3
`define B_BURST_AB 6
`define B_BURST_CD 7
`define UNLOCK_KEY 2'h3
`define ADDR_BITS 5'h08
`define FRAME_BITS 5'h10
`define RAMP_DIV 3'h7
`define TOG11_A 14'h0555
`define TOG11_B 14'h02aa
`define TOG14_A 14'h1555
`define TOG14_B 14'h2aaa
`define ONES11 14'h07ff
`define ONES14 14'h3fff
`define GAIN_FRAC 9
`endif

// File: common/adc_out_pkg.sv
// Types of the output path
package adc_out_pkg;
	typedef logic [13:0] sample_t;
	typedef enum logic [2:0] {
		PAT_NORMAL = 3'h0,
		PAT_ZEROS = 3'h1,
		PAT_ONES = 3'h2,
		PAT_TOGGLE = 3'h3,
		PAT_RAMP = 3'h4,
		PAT_CUSTOM = 3'h5
	} pat_e;
	typedef struct packed {
		logic [3:0] gain;
		logic skip;
		pat_e pat;
	} chan_cfg_s;
	typedef struct packed {
		logic readout;
		logic [5:0] swing;
		chan_cfg_s [3:0] ch;
		sample_t custom;
		logic digen;
		logic [1:0] burst;
		logic [1:0] unlock;
	} regs_s;
	typedef struct packed {
		sample_t [3:0] s;
	} samples_s;
endpackage

// File: tb/capture_sink.sv
// Data-capture sink that drains the output stream, with commanded stalls
`timescale 1ns/1ps

module capture_sink (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Commands from the bench
	input wire logic hold,
	input wire logic eager,
	// Stream handshake
	output logic ready
);
	int seed = 32'h811a;

	////////////////////////////////////////////////////////////////////////////////

	initial ready = 1'b0;

	always @(negedge clock) begin
		ready <= !rst && !hold && (eager || ($random(seed) % 4 != 0));
	end
endmodule

// File: tb/adc_out_path_bench.sv
// Bench for the output path: serial registers, swing, patterns, gain and FIFO
`timescale 1ns/1ps

module adc_out_path_bench
	import adc_out_pkg::*;
;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic SEN_N = 1'b1;
	logic SCLK = 1'b0;
	logic SDATA = 1'b0;
	logic IN_VALID = 1'b0;
	logic HOLD = 1'b1;
	logic EAGER = 1'b0;
	samples_s IN_DATA = '0;
	wire SERIAL_DATA_OUT_PIN, SERIAL_DATA_OUT_PIN_OE, IN_READY, OUT_VALID, OUT_READY;
	samples_s OUT_DATA, em, eo;
	logic [5:0] LVDS_SWING;
	int mismatches = 0;
	int check_count = 0;
	int seed = 32'h811a;
	int r[256];
	int tog[4];
	int rch = -1;
	int chad[4] = '{8'h2b, 8'h25, 8'h37, 8'h31};
	int six[6] = '{8'h00, 8'h01, 8'h2b, 8'h25, 8'h37, 8'h31};
	logic [5:0] codes[5] = '{6'h00, 6'h1b, 6'h32, 6'h14, 6'h0f};
	samples_s expq[$];
	int rampq[$];

	adc_out_path dut_u (.CLOCK(CLOCK), .RST(RST), .SEN_N(SEN_N), .SCLK(SCLK), .SDATA(SDATA),
		.SERIAL_DATA_OUT_PIN(SERIAL_DATA_OUT_PIN), .SERIAL_DATA_OUT_PIN_OE(SERIAL_DATA_OUT_PIN_OE), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
		.IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
		.LVDS_SWING(LVDS_SWING));
	capture_sink sink_u (.clock(CLOCK), .rst(RST), .hold(HOLD), .eager(EAGER), .ready(OUT_READY));

	always #2 CLOCK = ~CLOCK;

	////////////////////////////////////////////////////////////////////////////////

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task spi(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
		logic [15:0] w;
		w = {a, d};
		@(negedge CLOCK) SEN_N = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(negedge CLOCK) SCLK = 1'b0;
			SDATA = w[i];
			@(negedge CLOCK);
			if (i < 8)
				rd[i] = SERIAL_DATA_OUT_PIN_OE ? SERIAL_DATA_OUT_PIN : !SERIAL_DATA_OUT_PIN;
			SCLK = 1'b1;
		end
		@(negedge CLOCK) SCLK = 1'b0;
		@(negedge CLOCK) SEN_N = 1'b1;
		@(negedge CLOCK);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		spi(a, d, q);
		r[a] = d;
		if (a == 8'h00 && d[1])
			r = '{default: 0};
		foreach (chad[c])
			if (chad[c] == a)
				tog[c] = 0;
	endtask

	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		logic [7:0] want;
		want = r[0][0] ? exp : ~exp;
		spi(a, exp, q);
		chk("readback", q, want);
	endtask

	task send(input int n, input int msk);
		int k;
		repeat (n) begin
			@(negedge CLOCK) IN_VALID = 1'b1;
			for (int c = 0; c < 4; c++)
				IN_DATA.s[c] = sample_t'($random(seed) & msk);
			k = 0;
			while (!IN_READY && k < 500) begin
				@(negedge CLOCK);
				k++;
			end
			if (k >= 500)
				begin mismatches++; give_verdict(); end
		end
		@(negedge CLOCK) IN_VALID = 1'b0;
	endtask

	task drain;
		int k;
		k = 0;
		while (expq.size() > 0 && k < 3000) begin
			@(negedge CLOCK);
			k++;
		end
		if (k >= 3000)
			begin mismatches++; give_verdict(); end
	endtask

	function automatic sample_t model_word(int ch, int raw);
		int c;
		int w11;
		int cus;
		c = r[chad[ch]];
		w11 = ((r[8'h44] >> (6 + ch / 2)) & 1) == 0;
		cus = ((r[8'h3f] & 63) << 8) | r[8'h40];
		if (((r[8'h42] >> 3) & 1) && !((c >> 3) & 1) && (c >> 4) <= 12)
			raw = raw * $rtoi(512.0 * 10.0 ** ((c >> 4) / 40.0) + 0.5) / 512;
		if (raw > 16383)
			raw = 16383;
		case (c & 7)
			1: return 14'h0000;
			2: return w11 ? 14'h07ff : 14'h3fff;
			3: return w11 ? (tog[ch] ? 14'h02aa : 14'h0555) : (tog[ch] ? 14'h2aaa : 14'h1555);
			5: return sample_t'(w11 ? cus >> 3 : cus);
			default: return sample_t'(w11 ? raw >> 3 : raw);
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	always @(posedge CLOCK) begin
		if (!RST && IN_VALID && IN_READY) begin
			for (int ch = 0; ch < 4; ch++) begin
				em.s[ch] = model_word(ch, IN_DATA.s[ch]);
				if ((r[chad[ch]] & 7) == 3)
					tog[ch] ^= 1;
			end
			expq.push_back(em);
		end
	end

	always @(posedge CLOCK) begin
		if (!RST && OUT_VALID && OUT_READY) begin
			chk("pending", expq.size() > 0, 1);
			eo = expq.pop_front();
			for (int ch = 0; ch < 4; ch++)
				if (ch == rch)
					rampq.push_back(OUT_DATA.s[ch]);
				else
					chk("out word", OUT_DATA.s[ch], eo.s[ch]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		repeat (20) @(negedge CLOCK);
		RST = 1'b0;
		foreach (six[i])
			rdchk(six[i], 8'h00);
		rdchk(8'h50, 8'h00);
		chk("swing", LVDS_SWING, 0);
		chk("drive", SERIAL_DATA_OUT_PIN_OE, 0);
		wr(8'h00, 8'h01);
		chk("drive", SERIAL_DATA_OUT_PIN_OE, 1);
		wr(8'h2b, 8'h5a);
		rdchk(8'h2b, 8'h5a);
		wr(8'h00, 8'h02);
		chk("drive", SERIAL_DATA_OUT_PIN_OE, 0);
		rdchk(8'h2b, 8'h00);
		rdchk(8'h00, 8'h00);
		wr(8'h01, 8'h6c);
		chk("swing", LVDS_SWING, 0);
		wr(8'hf1, 8'h03);
		foreach (codes[i]) begin
			wr(8'h01, {codes[i], 2'b00});
			chk("swing", LVDS_SWING, codes[i]);
		end
		wr(8'hf1, 8'h00);
		chk("swing", LVDS_SWING, 0);
		HOLD = 1'b0;
		wr(8'h3f, 8'h2d);
		wr(8'h40, 8'ha7);
		for (int b = 0; b < 2; b++) begin
			wr(8'h44, b ? 8'hc0 : 8'h00);
			wr(8'h42, 8'h00);
			for (int c = 0; c < 4; c++) begin
				for (int p = 0; p < 6; p++) begin
					if (p != 4) begin
						wr(chad[c], 8'(p));
						send(5, 14'h3fff);
					end
				end
				wr(chad[c], 8'h00);
			end
			wr(8'h2b, 8'hc0);
			send(4, 14'h3f00);
			wr(8'h42, 8'h08);
			send(4, 14'h3f00);
			for (int g = 1; g < 12; g++) begin
				wr(8'h2b, 8'(g << 4));
				send(2, 14'h3fff);
			end
			wr(8'h2b, 8'hc8);
			send(4, 14'h3f00);
			wr(8'h2b, 8'h00);
			drain();
		end
		EAGER = 1'b1;
		for (int b = 0; b < 2; b++) begin
			wr(8'h44, b ? 8'hc0 : 8'h00);
			rch = 0;
			wr(8'h2b, 8'h04);
			send(24, 14'h3fff);
			drain();
			rch = -1;
			wr(8'h2b, 8'h00);
			for (int i = 0; i + (b ? 1 : 8) < rampq.size(); i++)
				chk("ramp step", (rampq[i + (b ? 1 : 8)] - rampq[i]) & 16383, 1);
			rampq.delete();
		end
		EAGER = 1'b0;
		HOLD = 1'b1;
		send(8, 14'h3fff);
		chk("in ready", IN_READY, 0);
		chk("out valid", OUT_VALID, 1);
		HOLD = 1'b0;
		drain();
		@(negedge CLOCK);
		chk("out valid", OUT_VALID, 0);
		RST = 1'b1;
		r = '{default: 0};
		repeat (3) @(negedge CLOCK);
		RST = 1'b0;
		rdchk(8'h44, 8'h00);
		give_verdict();
	end
endmodule
